// ### fptr_pkg.sv
// Package with opcodes, register addresses, defaults and sizes for the protection registers
package fptr_pkg;
  // Command opcodes
  localparam logic [7:0] OP_PROT_STATUS_READ = 8'ha7;
  localparam logic [7:0] OP_PROT_LOCK = 8'ha6;
  localparam logic [7:0] OP_GEN_READ = 8'h65;
  localparam logic [7:0] OP_GEN_WRITE = 8'h71;
  localparam logic [7:0] OP_SECT_LOCK3 = 8'h36;
  localparam logic [7:0] OP_SECT_LOCK4 = 8'he1;
  localparam logic [7:0] OP_SECT_UNLOCK3 = 8'h39;
  localparam logic [7:0] OP_SECT_UNLOCK4 = 8'he2;
  localparam logic [7:0] OP_SECT_READ3 = 8'h3d;
  localparam logic [7:0] OP_SECT_READ4 = 8'he0;
  localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7e;
  localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
  localparam logic [7:0] OP_SET_PTR3 = 8'hfb;
  localparam logic [7:0] OP_SET_PTR4 = 8'he3;
  localparam logic [7:0] OP_PROG_STORED = 8'h43;
  localparam logic [7:0] OP_WRITE_ACTIVE = 8'h4a;
  localparam logic [7:0] OP_PATTERN_READ = 8'h41;
  localparam logic [7:0] OP_SOFT_RESET = 8'h99;
  localparam logic [7:0] OP_ENTER_DDR_READ = 8'hed;
  // Generic register addresses
  localparam logic [31:0] ADDR_PROT_STATUS = 32'h0000_0020;
  localparam logic [31:0] ADDR_PTR_REGION = 32'h0000_0027;
  localparam logic [31:0] ADDR_STORED_PAT = 32'h0000_0010;
  localparam logic [31:0] ADDR_ACTIVE_PAT = 32'h0000_0011;
  // Field positions and defaults
  localparam int LOCK_BIT = 0;
  localparam int RRPW_BIT = 6;
  localparam int MODE_LOCKBOOT = 4;
  localparam int MODE_PASSWORD = 2;
  localparam int MODE_PERMANENT = 0;
  localparam logic [31:0] PTR_RESET = 32'hffff_ffff;
  localparam logic [31:0] PTR_WR_MASK = 32'h007f_fe00;
  localparam logic [7:0] STORED_PAT_RESET = 8'h00;
  localparam logic [7:0] LOCK_READ_LOCKED = 8'h00;
  localparam logic [7:0] LOCK_READ_OPEN = 8'hff;
  localparam logic [15:0] MODE_RESET = 16'hffff;
  // Sector lock array: one bit per 64 KB block of 8 MB
  localparam int SECT_BITS = 7;
  localparam int SECT_COUNT = 128;
  localparam int SECT_LSB = 16;
  localparam logic [3:0] LEARN_EDGES = 4'h8;
  // Command engine states
  typedef enum logic [2:0] {
    FPTR_IDLE = 3'b000,
    FPTR_OPC = 3'b001,
    FPTR_ADDR = 3'b011,
    FPTR_DATA = 3'b010,
    FPTR_OUT = 3'b110,
    FPTR_DONE = 3'b111
  } fptr_state_t;
endpackage

// ### fptr_sync.sv
// Two-flop synchroniser for one level
`timescale 1ns/1ps
module fptr_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Level in and out
  input wire logic din,
  output logic dout
);
  logic meta_q;
  // First flop read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// ### fptr_learn.sv
// Shifter that sends the learning pattern, one bit per serial clock edge
`timescale 1ns/1ps
module fptr_learn (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic edge_seen,
  input wire logic [7:0] pattern,
  // Output
  output logic drive,
  output logic bit_out
);
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  // Load on start, shift on each edge, MSB first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
    end else if (start) begin
      sh_q <= pattern;
      cnt_q <= (pattern == 8'h00) ? 4'h0 : fptr_pkg::LEARN_EDGES;
    end else if (edge_seen && cnt_q != 4'h0) begin
      sh_q <= {sh_q[6:0], 1'b0};
      cnt_q <= cnt_q - 4'h1;
    end
  end
  assign drive = (cnt_q != 4'h0);
  assign bit_out = sh_q[7];
endmodule

// ### fptr_top.sv
// Protection, sector lock and learning pattern registers behind the serial command port
// Notes on behaviour
// - Protection status is volatile read-only; reserved bits read zero.
// - With lock bit zero, pointer region changes are refused.
// - Lock bit defaults from protection-mode bits 2 and 0.
// - Protection lock command sets the lock bit to one.
// - Status bit 6 mirrors protection-mode bit 6.
// - Status readable by dedicated read and generic register read.
// - Sector lock read gives 00h when locked, FFh when open.
// - Sector lock commands lock one block; global lock locks all.
// - Sector unlock commands unlock one block; global unlock unlocks all.
// - Sector lock read commands, both address sizes, return the access value.
// - Pointer register is non-volatile only, default from hardware; here every hardware reset reloads PTR_RESET, so writes are lost.
// - Pointer register set by set-pointer commands and generic access.
// - Pointer address bits 22..12 default ones; reserved bits read ones.
// - Bit 11 selects protect-all, default one.
// - Bit 10 is active-low enable, default one.
// - Bit 9 selects direction, default one (bottom).
// - Stored pattern programs once only and copies into active pattern.
// - Active pattern writable any time; reloads from stored on reset.
// - Learning phase drives pattern MSB first on all data lines.
// - Active pattern 00h sends no preamble.
// - Pattern read command returns the learning pattern.
// - Reset state of sector locks follows lock-boot bit.
`timescale 1ns/1ps
module fptr_top (
  // System clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Serial pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] dq_in,
  output logic [3:0] dq_out,
  output logic [3:0] dq_oe_n,
  // Protection mode bits from the one-time area
  input wire logic [15:0] protection_mode_otp,
  // Status towards the array logic
  output logic protection_lock_bit,
  output logic [31:0] pointer_region_protection,
  output logic [7:0] learning_pattern_volatile
);
  logic rst_a_q, rst_b_q, rst_n;
  logic sck_s, cs_n_s, sck_prev_q;
  logic [3:0] dq_s;
  logic rise, fall;
  // Reset release through two flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_a_q <= 1'b0;
      rst_b_q <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_b_q <= rst_a_q;
    end
  end
  assign rst_n = rst_b_q;

  // Pin synchronisers
  fptr_sync u_sck (.clk(mclk), .rst_n(rst_n), .din(sck), .dout(sck_s));
  fptr_sync u_cs (.clk(mclk), .rst_n(rst_n), .din(~cs_n), .dout(cs_n_s));
  fptr_sync u_d0 (.clk(mclk), .rst_n(rst_n), .din(dq_in[0]), .dout(dq_s[0]));
  fptr_sync u_d1 (.clk(mclk), .rst_n(rst_n), .din(dq_in[1]), .dout(dq_s[1]));
  fptr_sync u_d2 (.clk(mclk), .rst_n(rst_n), .din(dq_in[2]), .dout(dq_s[2]));
  fptr_sync u_d3 (.clk(mclk), .rst_n(rst_n), .din(dq_in[3]), .dout(dq_s[3]));
  logic sel;
  assign sel = cs_n_s; // High while chip select is active

  // Serial clock edge detection
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
    end
  end
  assign rise = sck_s & ~sck_prev_q;
  assign fall = ~sck_s & sck_prev_q;

  // Reset strap capture of protection-mode bits after release
  logic init_q;
  logic [15:0] mode_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      init_q <= 1'b1;
      mode_q <= fptr_pkg::MODE_RESET;
    end else begin
      init_q <= 1'b0;
      if (init_q) begin
        mode_q <= protection_mode_otp;
      end
    end
  end

  // Command shifter
  fptr_pkg::fptr_state_t st_q;
  logic [7:0] opc_q;
  logic [31:0] addr_q;
  logic [5:0] acnt_q;
  logic [7:0] sh_q;
  logic [2:0] bcnt_q;
  logic [7:0] out_q;
  logic [31:0] wdata_q;
  logic [2:0] wbytes_q;
  logic byte_done;
  assign byte_done = rise && bcnt_q == 3'h7;
  logic [7:0] in_byte;
  assign in_byte = {sh_q[6:0], dq_s[0]};

  function automatic logic [5:0] addr_len(input logic [7:0] op);
    case (op)
      fptr_pkg::OP_SECT_LOCK4, fptr_pkg::OP_SECT_UNLOCK4,
      fptr_pkg::OP_SECT_READ4, fptr_pkg::OP_SET_PTR4: addr_len = 6'd32;
      fptr_pkg::OP_SECT_LOCK3, fptr_pkg::OP_SECT_UNLOCK3,
      fptr_pkg::OP_SECT_READ3, fptr_pkg::OP_SET_PTR3, fptr_pkg::OP_ENTER_DDR_READ,
      fptr_pkg::OP_GEN_READ, fptr_pkg::OP_GEN_WRITE: addr_len = 6'd24;
      default: addr_len = 6'd0;
    endcase
  endfunction

  // Read data selection
  logic [7:0] rd_byte;
  localparam int SECT_W = fptr_pkg::SECT_BITS;
  logic [SECT_W-1:0] sect_idx;
  logic [fptr_pkg::SECT_COUNT-1:0] lock_q;
  logic [7:0] prot_status;
  logic [7:0] stored_q;
  logic stored_done_q;
  logic [7:0] active_q;
  logic [31:0] ptr_q;
  logic lock_bit_q;
  assign sect_idx = addr_q[fptr_pkg::SECT_LSB +: SECT_W];
  // Bit 6 mirrors mode bit 6
  assign prot_status = {1'b0, mode_q[fptr_pkg::RRPW_BIT], 5'h00, lock_bit_q};
  always_comb begin
    rd_byte = 8'h00;
    case (opc_q)
      fptr_pkg::OP_PROT_STATUS_READ: rd_byte = prot_status;
      fptr_pkg::OP_SECT_READ3, fptr_pkg::OP_SECT_READ4:
        rd_byte = lock_q[sect_idx] ? fptr_pkg::LOCK_READ_LOCKED : fptr_pkg::LOCK_READ_OPEN;
      fptr_pkg::OP_PATTERN_READ: rd_byte = active_q;
      fptr_pkg::OP_GEN_READ: begin
        if (addr_q == fptr_pkg::ADDR_PROT_STATUS) begin
          rd_byte = prot_status;
        end else if (addr_q == fptr_pkg::ADDR_PTR_REGION) begin
          rd_byte = ptr_q[7:0];
        end else if (addr_q == fptr_pkg::ADDR_STORED_PAT) begin
          rd_byte = stored_q;
        end else if (addr_q == fptr_pkg::ADDR_ACTIVE_PAT) begin
          rd_byte = active_q;
        end
      end
      default: rd_byte = 8'h00;
    endcase
  end
  logic is_read;
  assign is_read = opc_q == fptr_pkg::OP_PROT_STATUS_READ || opc_q == fptr_pkg::OP_SECT_READ3
    || opc_q == fptr_pkg::OP_SECT_READ4 || opc_q == fptr_pkg::OP_PATTERN_READ
    || opc_q == fptr_pkg::OP_GEN_READ;

  // Command sequencing
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= fptr_pkg::FPTR_IDLE;
      opc_q <= 8'h00;
      addr_q <= 32'h0000_0000;
      acnt_q <= 6'd0;
      sh_q <= 8'h00;
      bcnt_q <= 3'h0;
      out_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wbytes_q <= 3'h0;
    end else begin
      case (st_q)
        fptr_pkg::FPTR_IDLE: begin
          bcnt_q <= 3'h0;
          wbytes_q <= 3'h0;
          if (sel) begin
            st_q <= fptr_pkg::FPTR_OPC;
          end
        end
        fptr_pkg::FPTR_OPC: begin
          if (!sel) begin
            st_q <= fptr_pkg::FPTR_DONE;
          end else if (rise) begin
            sh_q <= in_byte;
            bcnt_q <= bcnt_q + 3'h1;
            if (byte_done) begin
              opc_q <= in_byte;
              acnt_q <= addr_len(in_byte);
              addr_q <= 32'h0000_0000;
              if (addr_len(in_byte) != 6'd0) begin
                st_q <= fptr_pkg::FPTR_ADDR;
              end else if (in_byte == fptr_pkg::OP_PROT_STATUS_READ
                  || in_byte == fptr_pkg::OP_PATTERN_READ) begin
                st_q <= fptr_pkg::FPTR_OUT;
              end else begin
                st_q <= fptr_pkg::FPTR_DATA;
              end
            end
          end
        end
        fptr_pkg::FPTR_ADDR: begin
          if (!sel) begin
            st_q <= fptr_pkg::FPTR_DONE;
          end else if (rise) begin
            addr_q <= {addr_q[30:0], dq_s[0]};
            acnt_q <= acnt_q - 6'd1;
            if (acnt_q == 6'd1) begin
              st_q <= is_read ? fptr_pkg::FPTR_OUT : fptr_pkg::FPTR_DATA;
            end
          end
        end
        fptr_pkg::FPTR_DATA: begin
          if (!sel) begin
            st_q <= fptr_pkg::FPTR_DONE;
          end else if (rise) begin
            sh_q <= in_byte;
            bcnt_q <= bcnt_q + 3'h1;
            if (byte_done) begin
              wdata_q <= {wdata_q[23:0], in_byte};
              if (wbytes_q != 3'h4) begin
                wbytes_q <= wbytes_q + 3'h1;
              end
            end
          end
        end
        fptr_pkg::FPTR_OUT: begin
          if (!sel) begin
            st_q <= fptr_pkg::FPTR_DONE;
          end else if (fall) begin
            // Bytes repeat while the host keeps clocking
            out_q <= (bcnt_q == 3'h0) ? {rd_byte[6:0], 1'b0} : {out_q[6:0], 1'b0};
            bcnt_q <= bcnt_q + 3'h1;
          end
        end
        fptr_pkg::FPTR_DONE: st_q <= fptr_pkg::FPTR_IDLE;
        default: st_q <= fptr_pkg::FPTR_IDLE;
      endcase
    end
  end

  // Completed command strobes
  logic done;
  assign done = st_q == fptr_pkg::FPTR_DONE;
  logic gen_wr;
  assign gen_wr = done && opc_q == fptr_pkg::OP_GEN_WRITE && wbytes_q != 3'h0;

  // Lock bit: reset reload, set only by lock command
  // Held low until the strap capture so the lock output never falls after reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lock_bit_q <= 1'b0;
    end else if (init_q) begin
      lock_bit_q <= protection_mode_otp[fptr_pkg::MODE_PASSWORD]
        & protection_mode_otp[fptr_pkg::MODE_PERMANENT];
    end else if (done && opc_q == fptr_pkg::OP_PROT_LOCK) begin
      lock_bit_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= '1;
    end else if (init_q) begin
      lock_q <= {fptr_pkg::SECT_COUNT{protection_mode_otp[fptr_pkg::MODE_LOCKBOOT]}};
    end else if (done && st_q == fptr_pkg::FPTR_DONE && acnt_q == 6'd0) begin
      case (opc_q)
        fptr_pkg::OP_SECT_LOCK3, fptr_pkg::OP_SECT_LOCK4: lock_q[sect_idx] <= 1'b1;
        fptr_pkg::OP_SECT_UNLOCK3, fptr_pkg::OP_SECT_UNLOCK4: lock_q[sect_idx] <= 1'b0;
        fptr_pkg::OP_GLOBAL_LOCK: lock_q <= '1;
        fptr_pkg::OP_GLOBAL_UNLOCK: lock_q <= '0;
        default: lock_q <= lock_q;
      endcase
    end
  end

  logic ptr_cmd;
  logic [31:0] ptr_new;
  assign ptr_cmd = done && acnt_q == 6'd0
    && (opc_q == fptr_pkg::OP_SET_PTR3 || opc_q == fptr_pkg::OP_SET_PTR4);
  assign ptr_new = (ptr_cmd ? addr_q : wdata_q) & fptr_pkg::PTR_WR_MASK
    | ~fptr_pkg::PTR_WR_MASK;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= fptr_pkg::PTR_RESET;
    end else if (lock_bit_q && (ptr_cmd
        || (gen_wr && addr_q == fptr_pkg::ADDR_PTR_REGION))) begin
      // Refused while lock bit is zero
      ptr_q <= ptr_new;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stored_q <= fptr_pkg::STORED_PAT_RESET;
      stored_done_q <= 1'b0;
      active_q <= fptr_pkg::STORED_PAT_RESET;
    end else if (done && opc_q == fptr_pkg::OP_SOFT_RESET) begin
      active_q <= stored_q;
    end else if (done && opc_q == fptr_pkg::OP_PROG_STORED && wbytes_q != 3'h0) begin
      if (!stored_done_q) begin
        stored_q <= wdata_q[7:0];
        stored_done_q <= 1'b1;
        active_q <= wdata_q[7:0];
      end
    end else if ((done && opc_q == fptr_pkg::OP_WRITE_ACTIVE && wbytes_q != 3'h0)
        || (gen_wr && addr_q == fptr_pkg::ADDR_ACTIVE_PAT)) begin
      active_q <= wdata_q[7:0];
    end
  end

  // Learning preamble at start of DDR read dummy phase
  logic learn_start, learn_drive, learn_bit;
  assign learn_start = st_q == fptr_pkg::FPTR_ADDR && rise && acnt_q == 6'd1
    && opc_q == fptr_pkg::OP_ENTER_DDR_READ;
  fptr_learn u_learn (
    .clk(mclk),
    .rst_n(rst_n),
    .start(learn_start),
    .edge_seen(rise | fall),
    .pattern(active_q),
    .drive(learn_drive),
    .bit_out(learn_bit)
  );

  // Registered pin and status outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dq_out <= 4'h0;
      dq_oe_n <= 4'hf;
      protection_lock_bit <= 1'b0;
      pointer_region_protection <= fptr_pkg::PTR_RESET;
      learning_pattern_volatile <= fptr_pkg::STORED_PAT_RESET;
    end else begin
      if (learn_drive) begin
        dq_out <= {4{learn_bit}};
        dq_oe_n <= 4'h0;
      end else if (st_q == fptr_pkg::FPTR_OUT && sel) begin
        dq_out <= {2'b00, (bcnt_q == 3'h0) ? rd_byte[7] : out_q[7], 1'b0};
        dq_oe_n <= 4'hd;
      end else begin
        dq_out <= 4'h0;
        dq_oe_n <= 4'hf;
      end
      protection_lock_bit <= lock_bit_q;
      pointer_region_protection <= ptr_q;
      learning_pattern_volatile <= active_q;
    end
  end
endmodule

// ### fptr_top_assertions.sv
// Checker for the protection register block, bound to its top module
`timescale 1ns/1ps
module fptr_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Serial pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] dq_in,
  input wire logic [3:0] dq_out,
  input wire logic [3:0] dq_oe_n,
  // Mode bits and register outputs
  input wire logic [15:0] protection_mode_otp,
  input wire logic protection_lock_bit,
  input wire logic [31:0] pointer_region_protection,
  input wire logic [7:0] learning_pattern_volatile
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // Lock bit: default after reset, and only reset clears it
  a_lock_default: assert property ($rose(reset_n) |-> ##6
      protection_lock_bit == (protection_mode_otp[2] & protection_mode_otp[0]))
    else $error("lock bit default wrong after reset");
  a_lock_sticky: assert property (!$fell(protection_lock_bit))
    else $error("lock bit cleared without reset");
  // Pointer register: reserved ones, guarded by the lock, updated between frames
  a_ptr_reserved: assert property (
      (pointer_region_protection | fptr_pkg::PTR_WR_MASK) == 32'hffff_ffff)
    else $error("pointer reserved bits not ones");
  a_ptr_guard: assert property (
      $changed(pointer_region_protection) |-> $past(protection_lock_bit))
    else $error("pointer changed while lock bit zero");
  a_ptr_frame: assert property ($changed(pointer_region_protection) |-> cs_n)
    else $error("pointer changed inside a frame");
  a_pat_frame: assert property ($changed(learning_pattern_volatile) |-> cs_n)
    else $error("active pattern changed inside a frame");
  // Output lanes: idle off, one read lane, learning drives all lanes alike
  a_oe_idle: assert property (cs_n [*8] |-> dq_oe_n == 4'hf)
    else $error("lanes driven outside a frame");
  a_learn_lanes: assert property (
      dq_oe_n == 4'h0 |-> (dq_out == 4'h0 || dq_out == 4'hf))
    else $error("learning lanes differ");
  a_learn_zero: assert property (dq_oe_n == 4'h0 |-> learning_pattern_volatile != 8'h00)
    else $error("learning pattern sent while pattern zero");
  a_lane_modes: assert property (dq_oe_n inside {4'hf, 4'hd, 4'h0})
    else $error("unexpected lane enable set");
endmodule

bind fptr_top fptr_chk chk (
  .mclk, .reset_n, .sck, .cs_n, .dq_in, .dq_out, .dq_oe_n, .protection_mode_otp,
  .protection_lock_bit, .pointer_region_protection, .learning_pattern_volatile
);

// ### fptr_host.sv
// Host model that sends command frames on the serial pins
`timescale 1ns/1ps
module fptr_host (
  // Serial pins towards the block
  output logic sck,
  output logic cs_n,
  output logic [3:0] dq_in,
  // Wire levels and block enables
  input wire logic [3:0] dq,
  input wire logic [3:0] dq_oe_n
);
  // Enables and lane levels seen after each learning edge
  logic [7:0] lrn_q [8];
  // Clock stands low and select high outside frames
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    dq_in = 4'ha;
  end
  // One bit: data set while clock low, read lane taken mid low phase
  // The block shifts read data on falls, so its first bit stands before the first fall
  task automatic bit_x(input logic din, output logic dout);
    sck = 1'b0;
    dq_in = {~dq_in[3:1], din};
    #200;
    dout = dq[1];
    #200;
    sck = 1'b1;
    #400;
  endtask
  // Opcode, address, write bytes, optional learning edges, read bytes
  task automatic frame(input logic [7:0] op, input int na, input logic [31:0] a,
      input int nw, input logic [31:0] w, input int nr, input logic lrn,
      output logic [31:0] r);
    logic b;
    #37;
    cs_n = 1'b0;
    r = 32'h0;
    for (int i = 7; i >= 0; i--) bit_x(op[i], b);
    for (int i = na - 1; i >= 0; i--) bit_x(a[i], b);
    for (int i = 8 * nw - 1; i >= 0; i--) bit_x(w[i], b);
    // Each learning edge's lane value is taken 200 ns after that edge
    for (int k = 0; lrn && k < 8; k++) begin
      sck = ~sck;
      #200;
      lrn_q[k] = {dq_oe_n, dq};
      #200;
    end
    for (int i = 0; i < 8 * nr; i++) begin
      bit_x(1'b0, b);
      r = {r[30:0], b};
    end
    sck = 1'b0;
    #400;
    cs_n = 1'b1;
    dq_in = ~dq_in;
    #1000;
  endtask
endmodule

// ### tb.sv
// Self-checking bench for the protection, sector lock and pattern registers
`timescale 1ns/1ps
module tb;
  // Clock, reset, mode bits, pins and results
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] otp = 16'hffff;
  logic sck, cs_n, lock;
  logic [3:0] host_d, dq, dq_out, dq_oe_n;
  logic [31:0] ptr, r, v;
  logic [7:0] pat, q;
  int fails = 0;
  int num_checks = 0;
  int seed = 32'h8297b752;

  // System clock
  always #50 mclk = ~mclk;
  // Wire level: the block wins on lanes it enables
  assign dq = (~dq_oe_n & dq_out) | (dq_oe_n & host_d);

  fptr_top dut (
    .mclk, .reset_n, .sck, .cs_n, .dq_in(dq), .dq_out, .dq_oe_n,
    .protection_mode_otp(otp), .protection_lock_bit(lock),
    .pointer_region_protection(ptr), .learning_pattern_volatile(pat)
  );
  fptr_host host (.sck, .cs_n, .dq_in(host_d), .dq, .dq_oe_n);

  function automatic logic [7:0] status_exp(input logic [15:0] m, input logic lk);
    return {1'b0, m[6], 5'h00, lk};
  endfunction
  function automatic logic [31:0] ptr_exp(input logic [31:0] w);
    return w | ~fptr_pkg::PTR_WR_MASK;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Reset with a given set of mode bits, then let the capture settle
  task automatic do_reset(input logic [15:0] m);
    @(negedge mclk);
    reset_n = 1'b0;
    otp = m;
    repeat (12) @(negedge mclk);
    reset_n = 1'b1;
    repeat (8) @(negedge mclk);
  endtask
  task automatic cmd(input logic [7:0] op, input int na, input logic [31:0] a,
      input int nw, input logic [31:0] w, input int nr);
    host.frame(op, na, a, nw, w, nr, 1'b0, r);
  endtask
  // Optional command on one block, then read back its access value
  task automatic sect(input logic [7:0] op, input int w4, input logic [31:0] a,
      input logic [7:0] e);
    if (op != 8'h00) cmd(op, 24 + 8 * w4, a, 0, 0, 0);
    cmd(w4 ? fptr_pkg::OP_SECT_READ4 : fptr_pkg::OP_SECT_READ3, 24 + 8 * w4, a, 0, 0, 1);
    check(r, e);
  endtask

  initial begin
    do_reset(16'hffff);
    check(lock, 1'b1);
    check(ptr, 32'hffff_ffff);
    check(pat, 8'h00);
    cmd(fptr_pkg::OP_PROT_STATUS_READ, 0, 0, 0, 0, 1);
    check(r, status_exp(otp, 1'b1));
    cmd(fptr_pkg::OP_GEN_READ, 24, fptr_pkg::ADDR_PROT_STATUS, 0, 0, 1);
    check(r, status_exp(otp, 1'b1));
    v = $random(seed) & 32'h007f_ffff;
    sect(8'h00, 0, v, 8'h00);
    $display("test reset values done");
    // Block lock and unlock in both address sizes, top block included
    for (int i = 0; i < 2; i++) begin
      v = i ? 32'h007f_0000 | ($random(seed) & 32'hffff) : $random(seed) & 32'h007f_ffff;
      sect(i ? fptr_pkg::OP_SECT_UNLOCK4 : fptr_pkg::OP_SECT_UNLOCK3, i, v, 8'hff);
      sect(8'h00, i, v ^ 32'h0001_0000, 8'h00);
      sect(i ? fptr_pkg::OP_SECT_LOCK4 : fptr_pkg::OP_SECT_LOCK3, i, v, 8'h00);
    end
    cmd(fptr_pkg::OP_GLOBAL_UNLOCK, 0, 0, 0, 0, 0);
    sect(8'h00, 1, 32'h0, 8'hff);
    cmd(fptr_pkg::OP_GLOBAL_LOCK, 0, 0, 0, 0, 0);
    sect(8'h00, 0, v, 8'h00);
    $display("test sector locks done");
    // Pointer writes with random and all-zero values
    for (int i = 0; i < 2; i++) begin
      v = i ? 32'h0 : $random(seed);
      cmd(fptr_pkg::OP_SET_PTR4, 32, v, 0, 0, 0);
      check(ptr, ptr_exp(v));
    end
    cmd(fptr_pkg::OP_GEN_READ, 24, fptr_pkg::ADDR_PTR_REGION, 0, 0, 1);
    check(r, 8'hff);
    // Lock bit clear: pointer refused until the lock command
    do_reset(16'hffae);
    check(lock, 1'b0);
    sect(8'h00, 0, v, 8'hff);
    cmd(fptr_pkg::OP_PROT_STATUS_READ, 0, 0, 0, 0, 1);
    check(r, status_exp(otp, 1'b0));
    v = $random(seed);
    cmd(fptr_pkg::OP_SET_PTR3, 24, v, 0, 0, 0);
    check(ptr, 32'hffff_ffff);
    cmd(fptr_pkg::OP_PROT_LOCK, 0, 0, 0, 0, 0);
    check(lock, 1'b1);
    cmd(fptr_pkg::OP_GEN_READ, 24, fptr_pkg::ADDR_PROT_STATUS, 0, 0, 1);
    check(r, status_exp(otp, 1'b1));
    cmd(fptr_pkg::OP_SET_PTR4, 32, v, 0, 0, 0);
    cmd(fptr_pkg::OP_GLOBAL_UNLOCK, 0, 0, 0, 0, 0);
    check(ptr, ptr_exp(v));
    check(lock, 1'b1);
    do_reset(16'hffae);
    check(lock, 1'b0);
    $display("test pointer and lock done");
    // Stored pattern once only, active pattern writes, reads and learning
    q = $random(seed);
    q[0] = 1'b1;
    cmd(fptr_pkg::OP_PROG_STORED, 0, 0, 1, q, 0);
    check(pat, q);
    cmd(fptr_pkg::OP_PROG_STORED, 0, 0, 1, ~q, 0);
    cmd(fptr_pkg::OP_GEN_READ, 24, fptr_pkg::ADDR_STORED_PAT, 0, 0, 1);
    check(r, q);
    v = $random(seed);
    v[7] = 1'b1;
    cmd(fptr_pkg::OP_WRITE_ACTIVE, 0, 0, 1, v, 0);
    check(pat, v[7:0]);
    cmd(fptr_pkg::OP_PATTERN_READ, 0, 0, 0, 0, 1);
    check(r, v[7:0]);
    host.frame(fptr_pkg::OP_ENTER_DDR_READ, 24, v, 0, 0, 0, 1'b1, r);
    for (int k = 0; k < 8; k++) check(host.lrn_q[k], {4'h0, {4{v[7 - k]}}});
    cmd(fptr_pkg::OP_SOFT_RESET, 0, 0, 0, 0, 0);
    check(pat, q);
    cmd(fptr_pkg::OP_WRITE_ACTIVE, 0, 0, 1, 0, 0);
    host.frame(fptr_pkg::OP_ENTER_DDR_READ, 24, v, 0, 0, 0, 1'b1, r);
    for (int k = 0; k < 8; k++) check(host.lrn_q[k][7:4], 4'hf);
    $display("test learning pattern done");
    give_verdict();
  end

  // Watchdog well beyond the expected run of thirty-six frames
  initial begin
    #5_000_000;
    fails++;
    give_verdict();
  end
endmodule
